// File: design/spct_serial_port_ctrl.sv
// Serial port control register upper bits, clock polarity and periodic timer
//
// Contract
// RQ1 - The control register can be read and written by the processor core.
// RQ2 - Control bits 23 to 17 read as zero; software writes zeros there.
// RQ3 - Exception enable, receive full and any error raise the exception request.
// RQ4 - Hardware or software reset clears exception enable, polarity, rate, timer enable.
// RQ5 - Bit 15 picks clock pin polarity for driven and received clocks.
// RQ6 - Synchronous: positive idles high, low during data; negative the reverse.
// RQ7 - Asynchronous: positive rising edge at bit centre; negative falling edge there.
// RQ8 - Rate bit clear inserts divide by 32; set bypasses it.
// RQ9 - Software keeps the rate bit steady while the timer is enabled.
// RQ10 - Timer enable sends periodic timer requests at the divider rate.
// RQ11 - Timer acknowledge clears a pending timer request automatically.
// RQ12 - Port clock is divided by 16 to match the 1x baud rate.
// RQ13 - Timer runs even when no port pins are used for serial.
// RQ14 - Timer event occurs each time the baud counter reaches zero; here only every 16th zero, or every 512th with the rate bit clear.
// RQ15 - Exception request takes priority over the plain receive data request.
`timescale 1ns/10ps

module spct_serial_port_ctrl
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        soft_reset,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [23:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [23:0] reg_rdata,
  input  wire logic [11:0] clock_divider,
  input  wire logic        rx_full_flag,
  input  wire logic        parity_err_flag,
  input  wire logic        framing_err_flag,
  input  wire logic        overrun_err_flag,
  output logic             rx_exception_req,
  output logic             rx_data_req,
  output logic             timer_req,
  input  wire logic        timer_ack,
  input  wire logic        sync_mode,
  input  wire logic        clk_drive_en,
  input  wire logic        tx_active,
  input  wire logic        sclk_phase,
  input  wire logic        sclk_in,
  output logic             sclk_out,
  output logic             sclk_oe,
  output logic             sclk_rx
);

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  logic [23:0] serial_control;
  logic [23:0] next_serial_control;
  logic        rx_exception_irq_en;
  logic        clock_polarity_sel;
  logic        timer_rate_sel;
  logic        timer_irq_en;
  logic        rx_data_irq_en;

  always_comb
  begin
    next_serial_control = serial_control;
    // Software reset wins over a write in the same cycle
    if (soft_reset)
    begin
      next_serial_control = serial_control & ~spct_pkg::SOFT_RESET_MASK; // see RQ4
    end
    else if (reg_wr && (reg_addr == spct_pkg::SERIAL_CONTROL_OFS))
    begin
      next_serial_control = reg_wdata & spct_pkg::WRITABLE_MASK; // see RQ1, see RQ2
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      serial_control <= spct_pkg::SERIAL_CONTROL_RST; // see RQ4
    end
    else
    begin
      serial_control <= next_serial_control;
    end
  end

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  assign rx_exception_irq_en = serial_control[spct_pkg::RX_EXC_EN_BIT];
  assign clock_polarity_sel  = serial_control[spct_pkg::CLK_POL_BIT];
  assign timer_rate_sel      = serial_control[spct_pkg::TIMER_RATE_BIT];
  assign timer_irq_en        = serial_control[spct_pkg::TIMER_EN_BIT];
  assign rx_data_irq_en      = serial_control[spct_pkg::RX_DATA_EN_BIT];

  // ----------------------------------------------------------------
  // Receive requests
  // ----------------------------------------------------------------
  logic rx_error_any;
  logic next_rx_exception_req;
  logic next_rx_data_req;

  // Any one error flag is enough
  assign rx_error_any = parity_err_flag | framing_err_flag | overrun_err_flag;

  always_comb
  begin
    next_rx_exception_req = rx_exception_irq_en & rx_full_flag & rx_error_any; // see RQ3
    // Error with exception enabled suppresses the plain request
    next_rx_data_req      = rx_data_irq_en & rx_full_flag & ~next_rx_exception_req; // see RQ15
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rx_exception_req <= spct_pkg::REQ_RST;
    end
    else
    begin
      rx_exception_req <= next_rx_exception_req;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rx_data_req <= spct_pkg::REQ_RST;
    end
    else
    begin
      rx_data_req <= next_rx_data_req;
    end
  end

  // ----------------------------------------------------------------
  // Baud counter
  // ----------------------------------------------------------------
  logic [11:0] baud_cnt;
  logic        baud_zero;

  // Free running, independent of pin configuration
  assign baud_zero = (baud_cnt == spct_pkg::BAUD_CNT_RST); // see RQ14, see RQ13

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      baud_cnt <= spct_pkg::BAUD_CNT_RST;
    end
    else if (baud_zero)
    begin
      // A new divider takes effect at the next reload
      baud_cnt <= clock_divider;
    end
    else
    begin
      baud_cnt <= baud_cnt - 12'h001;
    end
  end

  // ----------------------------------------------------------------
  // Divide by 16 and optional divide by 32
  // ----------------------------------------------------------------
  logic [3:0] div16_cnt;
  logic [4:0] div32_cnt;
  logic       div16_tick;
  logic       div32_tick;
  logic       timer_tick;

  assign div16_tick = baud_zero & (div16_cnt == spct_pkg::DIV16_LAST); // see RQ12
  assign div32_tick = div16_tick & (div32_cnt == spct_pkg::DIV32_LAST);
  // Rate bit set bypasses the divide by 32
  assign timer_tick = timer_rate_sel ? div16_tick : div32_tick; // see RQ8

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      div16_cnt <= spct_pkg::DIV16_RST;
    end
    else if (baud_zero)
    begin
      // Wraps by itself after sixteen baud zeros
      div16_cnt <= div16_cnt + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // Divide by 32 stage
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      div32_cnt <= spct_pkg::DIV32_RST;
    end
    else if (div16_tick)
    begin
      div32_cnt <= div32_cnt + 5'h01;
    end
  end

  // ----------------------------------------------------------------
  // Timer request
  // ----------------------------------------------------------------
  logic timer_set;

  // Counters run free, so the first request after enable comes at any phase
  assign timer_set = timer_irq_en & timer_tick; // see RQ10

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      timer_req <= spct_pkg::REQ_RST;
    end
    else if (timer_set)
    begin
      // A new event beats an acknowledge in the same cycle
      timer_req <= 1'b1; // see RQ10
    end
    else if (timer_ack)
    begin
      // Acknowledge drops the request with no software action
      timer_req <= 1'b0; // see RQ11
    end
  end

  // ----------------------------------------------------------------
  // Clock pin polarity
  // ----------------------------------------------------------------
  logic next_sclk_out;

  always_comb
  begin
    if (sync_mode)
    begin
      // Gated clock: idle level is high for positive polarity
      next_sclk_out = (tx_active & sclk_phase) ^ ~clock_polarity_sel; // see RQ6, see RQ5
    end
    else
    begin
      // Phase rises at bit centre; inverted for negative polarity
      next_sclk_out = sclk_phase ^ clock_polarity_sel; // see RQ7, see RQ5
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      // Idle level of positive polarity, the polarity after reset
      sclk_out <= spct_pkg::SCLK_OUT_RST;
    end
    else
    begin
      sclk_out <= next_sclk_out;
    end
  end

  // Enable follows the drive request one cycle late, in step with the pin data
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sclk_oe <= spct_pkg::SCLK_OE_RST;
    end
    else
    begin
      sclk_oe <= clk_drive_en;
    end
  end

  // ----------------------------------------------------------------
  // Received clock
  // ----------------------------------------------------------------
  // Normalised to positive polarity for the receive side
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sclk_rx <= spct_pkg::SCLK_RX_RST;
    end
    else
    begin
      sclk_rx <= sclk_in ^ clock_polarity_sel; // see RQ5
    end
  end

  // ----------------------------------------------------------------
  // Status word
  // ----------------------------------------------------------------
  logic [23:0] status_word;

  // Read only: writes to the status offset are dropped
  always_comb
  begin
    status_word                                = 24'h000000;
    status_word[spct_pkg::ST_TIMER_PEND_BIT]   = timer_req;
    status_word[spct_pkg::ST_RX_EXC_BIT]       = rx_exception_req;
    status_word[spct_pkg::ST_RX_DATA_BIT]      = rx_data_req;
    status_word[spct_pkg::ST_TIMER_RATE_BIT]   = timer_rate_sel;
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  logic [23:0] next_reg_rdata;

  // Data stand for one cycle only, then fall back to zero
  always_comb
  begin
    next_reg_rdata = spct_pkg::RDATA_RST;
    if (reg_rd)
    begin
      case (reg_addr)
        spct_pkg::SERIAL_CONTROL_OFS:
        begin
          next_reg_rdata = serial_control; // see RQ1, see RQ2
        end
        spct_pkg::SERIAL_STATUS_OFS:
        begin
          next_reg_rdata = status_word;
        end
        default:
        begin
          // Unmapped offsets read as zero
          next_reg_rdata = spct_pkg::RDATA_RST;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      reg_rdata <= spct_pkg::RDATA_RST;
    end
    else
    begin
      reg_rdata <= next_reg_rdata;
    end
  end

endmodule

// File: design/spct_pkg.sv
// Constants for the serial port control and timer block
package spct_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W             = 4;
  localparam int unsigned DATA_W             = 24;
  localparam logic [3:0]  SERIAL_CONTROL_OFS = 4'h0;
  localparam logic [3:0]  SERIAL_STATUS_OFS  = 4'h4;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int unsigned RSV_HI_BIT         = 23;
  localparam int unsigned RSV_LO_BIT         = 17;
  localparam int unsigned RX_EXC_EN_BIT      = 16;
  localparam int unsigned CLK_POL_BIT        = 15;
  localparam int unsigned TIMER_RATE_BIT     = 14;
  localparam int unsigned TIMER_EN_BIT       = 13;
  localparam int unsigned RX_DATA_EN_BIT     = 11;
  localparam logic [23:0] SERIAL_CONTROL_RST = 24'h000000;
  localparam logic [23:0] WRITABLE_MASK      = 24'h01ffff;
  localparam logic [23:0] SOFT_RESET_MASK    = 24'h01e000;

  // ----------------------------------------------------------------
  // Status register fields
  // ----------------------------------------------------------------
  localparam int unsigned ST_TIMER_PEND_BIT  = 0;
  localparam int unsigned ST_RX_EXC_BIT      = 1;
  localparam int unsigned ST_RX_DATA_BIT     = 2;
  localparam int unsigned ST_TIMER_RATE_BIT  = 3;

  // ----------------------------------------------------------------
  // Timer chain
  // ----------------------------------------------------------------
  localparam int unsigned BAUD_W             = 12;
  localparam logic [3:0]  DIV16_LAST         = 4'hf;
  localparam logic [4:0]  DIV32_LAST         = 5'h1f;
  localparam logic [11:0] BAUD_CNT_RST       = 12'h000;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic        REQ_RST            = 1'b0;
  localparam logic        SCLK_OUT_RST       = 1'b1;
  localparam logic        SCLK_OE_RST        = 1'b0;
  localparam logic        SCLK_RX_RST        = 1'b0;
  localparam logic [23:0] RDATA_RST          = 24'h000000;
  localparam logic [3:0]  DIV16_RST          = 4'h0;
  localparam logic [4:0]  DIV32_RST          = 5'h00;

endpackage

// File: sim/spct_serial_port_ctrl_sva.sv
// Assertion checker for the serial port control block
`timescale 1ns/10ps
module spct_serial_port_ctrl_sva
(
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        soft_reset,
  input wire logic        reg_rd,
  input wire logic [23:0] reg_rdata,
  input wire logic        rx_full_flag,
  input wire logic        parity_err_flag,
  input wire logic        framing_err_flag,
  input wire logic        overrun_err_flag,
  input wire logic        rx_exception_req,
  input wire logic        rx_data_req,
  input wire logic        timer_req,
  input wire logic        timer_ack,
  input wire logic        sync_mode,
  input wire logic        sclk_phase,
  input wire logic        sclk_in,
  input wire logic        sclk_out,
  input wire logic        sclk_rx
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  rsv_read_zero_a: assert property (reg_rdata[23:17] == 7'h00)
    else $error("reserved bits read nonzero");
  read_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 24'h000000)
    else $error("read data outside read cycle");
  exc_cause_a: assert property (rx_exception_req |-> $past(rx_full_flag
    && (parity_err_flag || framing_err_flag || overrun_err_flag))) else $error("exception cause");
  rx_prio_a: assert property (!(rx_exception_req && rx_data_req))
    else $error("both receive requests");
  soft_clear_a: assert property (soft_reset |-> ##2 !rx_exception_req)
    else $error("exception after soft reset");
  ack_clear_a: assert property (timer_ack [*2] |=> !timer_req || !$past(timer_req))
    else $error("timer ack ignored");
  timer_hold_a: assert property (timer_req && !timer_ack |=> timer_req)
    else $error("timer request dropped without ack");
  timer_space_a: assert property ($rose(timer_req) |=> !$rose(timer_req) [*8])
    else $error("timer requests too close");
  pin_pol_a: assert property ($past(resetn) && $past(!sync_mode) |->
    (sclk_rx ^ sclk_out) == $past(sclk_in ^ sclk_phase)) else $error("clock polarity");
endmodule
bind spct_serial_port_ctrl spct_serial_port_ctrl_sva chk_u (.clk(clk), .resetn(resetn),
  .soft_reset(soft_reset), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_full_flag(rx_full_flag),
  .parity_err_flag(parity_err_flag), .framing_err_flag(framing_err_flag),
  .overrun_err_flag(overrun_err_flag), .rx_exception_req(rx_exception_req),
  .rx_data_req(rx_data_req), .timer_req(timer_req), .timer_ack(timer_ack),
  .sync_mode(sync_mode), .sclk_phase(sclk_phase), .sclk_in(sclk_in), .sclk_out(sclk_out),
  .sclk_rx(sclk_rx));

// File: sim/spct_remote_clk.sv
// Far-side serial device that drives the clock pin when the port does not
`timescale 1ns/10ps
module spct_remote_clk
(
  input  wire logic run,
  input  wire logic neg_pol,
  input  wire logic sclk_oe,
  input  wire logic sclk_out,
  output logic      sclk_in
);
  logic ext = 1'b1;
  // Toggles only within a frame, else rests at the idle level
  always #7 ext = run ? !ext : !neg_pol;
  assign sclk_in = sclk_oe ? sclk_out : ext;
endmodule

// File: sim/spct_serial_port_ctrl_tb.sv
// Self-checking bench for the serial port control block
`timescale 1ns/10ps
module spct_serial_port_ctrl_tb;
  logic clk = 0, resetn = 0, soft_reset = 0, reg_wr = 0, reg_rd = 0, timer_ack = 0;
  logic sync_mode = 0, clk_drive_en = 0, tx_active = 0, sclk_phase = 1, run = 0, neg_pol = 0;
  logic ful = 0, pe = 0, fe = 0, ov = 0, exc, dat, treq, sclk_in, sclk_out, sclk_oe, sclk_rx;
  logic [3:0]  reg_addr = 0;
  logic [23:0] reg_wdata = 0, reg_rdata;
  logic [11:0] clock_divider = 0;
  int          n_mismatch = 0, check_count = 0, cyc = 0, t0, t1;
  logic [51:0] rows [5] = '{{4'h0, 24'hffffff, 24'h01ffff}, {4'h4, 24'h0, 24'h01ffff},
    {4'h8, 24'h0, 24'h01ffff}, {4'h0, 24'h00a000, 24'h00a000}, {4'h0, 24'h0, 24'h0}};
  logic [35:0] trow [3] = '{{24'h006000, 12'h000}, {24'h006000, 12'h002}, {24'h002000, 12'h000}};
  always #2.5 clk = !clk;
  always @(posedge clk) cyc <= cyc + 1;
  spct_serial_port_ctrl dut_u (.clk(clk), .resetn(resetn), .soft_reset(soft_reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .clock_divider(clock_divider), .rx_full_flag(ful),
    .parity_err_flag(pe), .framing_err_flag(fe), .overrun_err_flag(ov),
    .rx_exception_req(exc), .rx_data_req(dat), .timer_req(treq), .timer_ack(timer_ack),
    .sync_mode(sync_mode), .clk_drive_en(clk_drive_en), .tx_active(tx_active),
    .sclk_phase(sclk_phase), .sclk_in(sclk_in), .sclk_out(sclk_out), .sclk_oe(sclk_oe),
    .sclk_rx(sclk_rx));
  spct_remote_clk far_u (.run(run), .neg_pol(neg_pol), .sclk_oe(sclk_oe),
    .sclk_out(sclk_out), .sclk_in(sclk_in));
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp, input string what);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [23:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [23:0] exp, input string what);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(reg_rdata, exp, what);
  endtask
  task automatic wait_req(output int t);
    for (int n = 0; treq !== 1'b1 && n < 3000; n++)
      @(negedge clk);
    chk(treq, 1'b1, "timer request");
    t = cyc;
  endtask
  task automatic ack_req();
    @(posedge clk);
    timer_ack <= 1'b1;
    repeat (2) @(posedge clk);
    timer_ack <= 1'b0;
    @(negedge clk);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    #100us;
    n_mismatch++;
    stop_test();
  end
  initial
  begin
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    rd(4'h0, 24'h0, "control reset");
    rd(4'h4, 24'h0, "status reset");
    foreach (rows[i])
    begin
      wr(rows[i][51:48], rows[i][47:24]);
      rd(4'h0, rows[i][23:0], "control");
    end
    rd(4'h8, 24'h0, "unmapped");
    wr(4'h0, 24'h01ffff);
    @(posedge clk) soft_reset <= 1'b1;
    @(posedge clk) soft_reset <= 1'b0;
    rd(4'h0, 24'h001fff, "soft reset");
    $display("test registers done");
    wr(4'h0, 24'h010800);
    ful <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk) {pe, fe, ov} <= 3'b100 >> i;
      repeat (2) @(negedge clk);
      chk({dat, exc}, {i == 3, i < 3}, "receive requests");
    end
    // Software reset drops the exception enable under a standing error
    @(posedge clk) pe <= 1'b1;
    @(posedge clk) soft_reset <= 1'b1;
    @(posedge clk) soft_reset <= 1'b0;
    repeat (2) @(negedge clk);
    chk({dat, exc}, 2'b10, "exception disabled");
    $display("test receive done");
    // Serial pins stay unused while the timer runs
    foreach (trow[i])
    begin
      wr(4'h0, 24'h0);
      clock_divider <= trow[i][11:0];
      wr(4'h0, trow[i][35:12]);
      wait_req(t0);
      ack_req();
      wait_req(t0);
      ack_req();
      wait_req(t1);
      chk(t1 - t0, (trow[i][26] ? 16 : 512) * (trow[i][11:0] + 1), "period");
      rd(4'h4, {20'h0, trow[i][26], 3'b001}, "status");
    end
    wr(4'h0, 24'h0);
    wr(4'h0, 24'h004000);
    clock_divider <= 12'h000;
    ack_req();
    repeat (600) @(negedge clk);
    chk(treq, 1'b0, "timer off");
    $display("test timer done");
    for (int p = 0; p < 2; p++)
    begin
      wr(4'h0, 24'(p) << 15);
      {neg_pol, sync_mode, clk_drive_en, tx_active} <= {p[0], 3'b110};
      repeat (3) @(negedge clk);
      chk(sclk_out, !p[0], "sync idle");
      @(posedge clk) tx_active <= 1'b1;
      repeat (2) @(negedge clk);
      chk(sclk_out, p[0], "sync active");
      @(posedge clk) {sync_mode, clk_drive_en} <= 2'b00;
      repeat (4) @(negedge clk);
      chk({sclk_rx, sclk_out}, {1'b1, !p[0]}, "async clock");
      @(posedge clk) {run, sclk_phase} <= 2'b10;
      repeat (2) @(negedge clk);
      chk(sclk_out, p[0], "async phase");
      repeat (20) @(posedge clk);
      {run, sclk_phase} <= 2'b01;
    end
    $display("test polarity done");
    stop_test();
  end
endmodule
